// [hw/fbm_defines.vh]
// What this block does
// - token goes to next master so each master gets it within target rotation time
// - slave exchanges start only while this master holds the token
// - after token arrival master acts for a bounded hold period, then passes on
// - broadcast addresses all other stations and expects no acknowledgement
// - multicast addresses a predefined group and expects no acknowledgement
// - one independent exchange timeout timer per assigned slave
// - timer expires without correct exchange in interval; user gets an event
// - transfer error with auto clear: leave Operate, fail-safe all slaves, enter Clear
// - transfer error without auto clear: stay in Operate
// - Off-line stops all communication with every participant
// - Stop: no slave exchanges, class 2 master traffic still allowed
// - Clear: send parameters, check configuration, then exchange data per slave
// - Clear data exchange reads inputs and writes all zero outputs
// - Operate: read slave inputs, write application outputs
// - Operate: multicast own state to slaves at configurable interval
// - collect slave diagnostics and keep them available for fault location
// - diagnostics carry one of three levels: device, module, channel
// - one common bit rate for all stations chosen at commissioning
`ifndef FBM_DEFINES_VH
`define FBM_DEFINES_VH
// ============================================================
// network states
`define FBM_ST_OFFLINE 2'h0
`define FBM_ST_STOP    2'h1
`define FBM_ST_CLEAR   2'h2
`define FBM_ST_OPERATE 2'h3
// ============================================================
// request kinds to the frame engine
`define FBM_K_PARAM    3'h0
`define FBM_K_CFGCHK   3'h1
`define FBM_K_DATA     3'h2
`define FBM_K_BCAST    3'h3
`define FBM_K_MCAST    3'h4
`define FBM_K_MASTER2  3'h5
`define FBM_K_FAILSAFE 3'h6
// ============================================================
// per slave start up phase
`define FBM_PH_PARAM   2'h0
`define FBM_PH_CFGCHK  2'h1
`define FBM_PH_DATA    2'h2
// ============================================================
// sizes and addresses
`define FBM_NSLV       4
`define FBM_SIDX_W     2
`define FBM_LAST_SLV   2'h3
`define FBM_ADDR_W     4
`define FBM_BCAST_ADDR 4'hf
`define FBM_GROUP_ADDR 4'he
`define FBM_DATA_W     8
`define FBM_TMR_W      16
`define FBM_TMR_ONE    16'h0001
`define FBM_TMR_ZERO   16'h0000
`define FBM_DIAG_W     12
`define FBM_FIFO_DEPTH 8
`define FBM_FIFO_AW    3
`endif

// [hw/fbm_fifo.v]
`timescale 1ns/100ps
`default_nettype none
module fbm_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             rstN,
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);
  // ============================================================
  // storage and pointers
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wrPtr_r;
  reg [AW-1:0]    rdPtr_r;
  reg [AW:0]      count_r;
  reg             full_r;
  reg             empty_r;
  wire            doWr;
  wire            doRd;
  wire [AW:0]     countNxt;

  assign doWr     = inValid & ~full_r;
  assign doRd     = outReady & ~empty_r;
  assign countNxt = doWr & ~doRd ? count_r + 1'b1 :
                    doRd & ~doWr ? count_r - 1'b1 : count_r;
  assign inReady  = ~full_r;
  assign outValid = ~empty_r;
  assign outData  = mem[rdPtr_r];

  always @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr_r] <= inData;
    end
  end

  // flags registered so ready and valid never ripple through
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrPtr_r <= {AW{1'b0}};
      rdPtr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
      full_r  <= 1'b0;
      empty_r <= 1'b1;
    end else begin
      if (doWr) begin
        wrPtr_r <= (wrPtr_r == DEPTH - 1) ? {AW{1'b0}} : wrPtr_r + 1'b1;
      end
      if (doRd) begin
        rdPtr_r <= (rdPtr_r == DEPTH - 1) ? {AW{1'b0}} : rdPtr_r + 1'b1;
      end
      count_r <= countNxt;
      full_r  <= (countNxt == DEPTH);
      empty_r <= (countNxt == {(AW+1){1'b0}});
    end
  end
endmodule
`default_nettype wire

// [hw/fbm_master.v]
`timescale 1ns/100ps
`default_nettype none
`include "fbm_defines.vh"
module fbm_master (
  input  wire                                clk,
  input  wire                                nrst,
  input  wire                                cmdValid,
  input  wire [1:0]                          cmdState,
  input  wire                                autoClear,
  input  wire [`FBM_TMR_W-1:0]               monInterval,
  input  wire [`FBM_TMR_W-1:0]               statusInterval,
  input  wire [`FBM_TMR_W-1:0]               tokenHoldTime,
  input  wire [3:0]                          baudSel,
  input  wire                                tokenIn,
  input  wire                                bcastReq,
  input  wire                                master2Req,
  input  wire                                reqReady,
  input  wire                                exchDone,
  input  wire [`FBM_SIDX_W-1:0]              exchSlave,
  input  wire                                exchOk,
  input  wire [`FBM_DATA_W-1:0]              exchIn,
  input  wire                                xferErr,
  input  wire [`FBM_NSLV*`FBM_DATA_W-1:0]    appOut,
  input  wire                                diagValid,
  input  wire [`FBM_DIAG_W-1:0]              diagIn,
  input  wire                                diagReady,
  output reg                                 tokenPass_r,
  output reg                                 reqValid_r,
  output reg  [2:0]                          reqKind_r,
  output reg  [`FBM_ADDR_W-1:0]              reqAddr_r,
  output reg  [`FBM_DATA_W-1:0]              reqData_r,
  output reg  [1:0]                          netState_r,
  output reg  [3:0]                          baudSel_r,
  output reg  [`FBM_NSLV-1:0]                timeoutEvt_r,
  output reg  [`FBM_NSLV-1:0]                timeoutSeen_r,
  output reg  [`FBM_NSLV*`FBM_DATA_W-1:0]    slvInImg_r,
  output wire                                diagInReady,
  output wire                                diagOutValid,
  output wire [`FBM_DIAG_W-1:0]              diagOut
);
  // ============================================================
  // reset release
  reg rstS1_r;
  reg rstN;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstS1_r <= 1'b0;
      rstN    <= 1'b0;
    end else begin
      rstS1_r <= 1'b1;
      rstN    <= rstS1_r;
    end
  end

  // ============================================================
  // token pin synchroniser
  reg tokS1_r;
  reg tokS2_r;
  reg tokS3_r;
  reg tokLvl_r;
  reg tokLvlD_r;
  wire tokArrive;
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      tokS1_r   <= 1'b0;
      tokS2_r   <= 1'b0;
      tokS3_r   <= 1'b0;
      tokLvl_r  <= 1'b0;
      tokLvlD_r <= 1'b0;
    end else begin
      tokS1_r   <= tokenIn;
      tokS2_r   <= tokS1_r;
      tokS3_r   <= tokS2_r;
      // change counts only once stages two and three agree
      if (tokS2_r == tokS3_r) begin
        tokLvl_r <= tokS3_r;
      end
      tokLvlD_r <= tokLvl_r;
    end
  end
  assign tokArrive = tokLvl_r & ~tokLvlD_r;

  // ============================================================
  // per slave exchange timeout timers
  wire                 inService;
  wire [`FBM_NSLV-1:0] expire;
  wire                 anyExpire;
  assign inService = (netState_r == `FBM_ST_CLEAR) | (netState_r == `FBM_ST_OPERATE);
  assign anyExpire = |expire;

  genvar gi;
  generate
    for (gi = 0; gi < `FBM_NSLV; gi = gi + 1) begin : gTmr
      reg  [`FBM_TMR_W-1:0] cnt_r;
      wire                  restart;
      assign restart = exchDone & exchOk & (exchSlave == gi);
      // interval sampled at each restart, so config can change live
      always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
          cnt_r <= `FBM_TMR_ZERO;
        end else if (!inService || restart) begin
          cnt_r <= monInterval;
        end else if (cnt_r != `FBM_TMR_ZERO) begin
          cnt_r <= cnt_r - `FBM_TMR_ONE;
        end
      end
      assign expire[gi] = inService & ~restart & (cnt_r == `FBM_TMR_ONE);
    end
  endgenerate

  // ============================================================
  // diagnostics buffer
  fbm_fifo #(
    .WIDTH (`FBM_DIAG_W),
    .DEPTH (`FBM_FIFO_DEPTH),
    .AW    (`FBM_FIFO_AW)
  ) uDiag (
    .clk      (clk),
    .rstN     (rstN),
    .inValid  (diagValid),
    .inReady  (diagInReady),
    .inData   (diagIn),
    .outValid (diagOutValid),
    .outReady (diagReady),
    .outData  (diagOut)
  );

  // ============================================================
  // token holding, scheduling, network state
  reg                    holding_r;
  reg [`FBM_TMR_W-1:0]   holdCnt_r;
  reg [`FBM_TMR_W-1:0]   statCnt_r;
  reg                    statDue_r;
  reg                    bcastPend_r;
  reg                    m2Pend_r;
  reg                    failPend_r;
  reg [`FBM_SIDX_W-1:0]  slvIdx_r;
  reg [2*`FBM_NSLV-1:0]  phase_r;
  reg [1:0]              curPh;
  wire                   issue;
  wire                   holdOver;
  wire                   errEvt;

  assign issue    = holding_r & (~reqValid_r | reqReady);
  assign holdOver = (holdCnt_r == `FBM_TMR_ZERO);
  assign errEvt   = (xferErr | anyExpire) & (netState_r == `FBM_ST_OPERATE);

  always @* begin
    curPh = phase_r[2*slvIdx_r +: 2];
  end

  integer k;
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      netState_r    <= `FBM_ST_OFFLINE;
      tokenPass_r   <= 1'b0;
      reqValid_r    <= 1'b0;
      reqKind_r     <= `FBM_K_PARAM;
      reqAddr_r     <= {`FBM_ADDR_W{1'b0}};
      reqData_r     <= {`FBM_DATA_W{1'b0}};
      baudSel_r     <= 4'h0;
      timeoutEvt_r  <= {`FBM_NSLV{1'b0}};
      timeoutSeen_r <= {`FBM_NSLV{1'b0}};
      slvInImg_r    <= {(`FBM_NSLV*`FBM_DATA_W){1'b0}};
      holding_r     <= 1'b0;
      holdCnt_r     <= `FBM_TMR_ZERO;
      statCnt_r     <= `FBM_TMR_ZERO;
      statDue_r     <= 1'b0;
      bcastPend_r   <= 1'b0;
      m2Pend_r      <= 1'b0;
      failPend_r    <= 1'b0;
      slvIdx_r      <= {`FBM_SIDX_W{1'b0}};
      phase_r       <= {(2*`FBM_NSLV){1'b0}};
    end else begin
      tokenPass_r  <= 1'b0;
      baudSel_r    <= baudSel;
      timeoutEvt_r <= expire;
      timeoutSeen_r <= timeoutSeen_r | expire;
      if (reqValid_r && reqReady) begin
        reqValid_r <= 1'b0;
      end
      // a timed out slave restarts its parameter sequence
      for (k = 0; k < `FBM_NSLV; k = k + 1) begin
        if (expire[k] || !inService) begin
          phase_r[2*k +: 2] <= `FBM_PH_PARAM;
        end
      end
      if (exchDone && exchOk && inService) begin
        case (phase_r[2*exchSlave +: 2])
          `FBM_PH_PARAM:  phase_r[2*exchSlave +: 2] <= `FBM_PH_CFGCHK;
          `FBM_PH_CFGCHK: phase_r[2*exchSlave +: 2] <= `FBM_PH_DATA;
          default: begin
            slvInImg_r[`FBM_DATA_W*exchSlave +: `FBM_DATA_W] <= exchIn;
          end
        endcase
      end
      // token arrival starts a bounded hold period
      if (tokArrive && !holding_r && netState_r != `FBM_ST_OFFLINE) begin
        holding_r <= 1'b1;
        holdCnt_r <= tokenHoldTime;
        slvIdx_r  <= {`FBM_SIDX_W{1'b0}};
      end else if (holding_r && !holdOver) begin
        holdCnt_r <= holdCnt_r - `FBM_TMR_ONE;
      end
      // off-line drops hold, request, status and fail-safe flags at once, keeps pending broadcast and class 2 requests, token is not forwarded
      if (netState_r == `FBM_ST_OFFLINE) begin
        holding_r   <= 1'b0;
        reqValid_r  <= 1'b0;
        statDue_r   <= 1'b0;
        failPend_r  <= 1'b0;
      end else if (issue) begin
        reqValid_r <= 1'b1;
        reqData_r  <= {`FBM_DATA_W{1'b0}};
        if (holdOver) begin
          reqValid_r  <= 1'b0;
          holding_r   <= 1'b0;
          tokenPass_r <= 1'b1;
        end else if (failPend_r) begin
          reqKind_r  <= `FBM_K_FAILSAFE;
          reqAddr_r  <= `FBM_GROUP_ADDR;
          failPend_r <= 1'b0;
        end else if (netState_r == `FBM_ST_STOP) begin
          if (m2Pend_r) begin
            reqKind_r <= `FBM_K_MASTER2;
            reqAddr_r <= {`FBM_ADDR_W{1'b0}};
            m2Pend_r  <= 1'b0;
          end else begin
            reqValid_r  <= 1'b0;
            holding_r   <= 1'b0;
            tokenPass_r <= 1'b1;
          end
        end else if (bcastPend_r) begin
          reqKind_r   <= `FBM_K_BCAST;
          reqAddr_r   <= `FBM_BCAST_ADDR;
          bcastPend_r <= 1'b0;
        end else if (statDue_r && netState_r == `FBM_ST_OPERATE) begin
          reqKind_r <= `FBM_K_MCAST;
          reqAddr_r <= `FBM_GROUP_ADDR;
          reqData_r <= {{(`FBM_DATA_W-2){1'b0}}, netState_r};
          statDue_r <= 1'b0;
        end else begin
          // one poll per slave per token visit
          reqAddr_r <= {{(`FBM_ADDR_W-`FBM_SIDX_W){1'b0}}, slvIdx_r};
          case (curPh)
            `FBM_PH_PARAM:  reqKind_r <= `FBM_K_PARAM;
            `FBM_PH_CFGCHK: reqKind_r <= `FBM_K_CFGCHK;
            default: begin
              reqKind_r <= `FBM_K_DATA;
              if (netState_r == `FBM_ST_OPERATE) begin
                reqData_r <= appOut[`FBM_DATA_W*slvIdx_r +: `FBM_DATA_W];
              end
            end
          endcase
          if (slvIdx_r == `FBM_LAST_SLV) begin
            holdCnt_r <= `FBM_TMR_ZERO;
          end else begin
            slvIdx_r <= slvIdx_r + 1'b1;
          end
        end
      end
      // placed after the issue logic so a new due or error beats its own clear
      // status interval counter, only meaningful in operate
      if (netState_r != `FBM_ST_OPERATE) begin
        statCnt_r <= statusInterval;
      end else if (statCnt_r == `FBM_TMR_ZERO) begin
        statCnt_r <= statusInterval;
        statDue_r <= 1'b1;
      end else begin
        statCnt_r <= statCnt_r - `FBM_TMR_ONE;
      end
      // state changes: command or auto clear only
      if (errEvt && autoClear) begin
        netState_r <= `FBM_ST_CLEAR;
        failPend_r <= 1'b1;
      end else if (cmdValid) begin
        netState_r <= cmdState;
      end
      // requests that arrive while their flag clears are kept
      if (bcastReq) begin
        bcastPend_r <= 1'b1;
      end
      if (master2Req) begin
        m2Pend_r <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/fbm_master_sva.sv]
`timescale 1ns/100ps
`default_nettype none
`include "fbm_defines.vh"
module fbm_master_sva (
  input wire       clk,
  input wire       nrst,
  input wire       cmdValid,
  input wire       autoClear,
  input wire       xferErr,
  input wire       reqReady,
  input wire       reqValid_r,
  input wire [2:0] reqKind_r,
  input wire [3:0] reqAddr_r,
  input wire [7:0] reqData_r,
  input wire [1:0] netState_r,
  input wire       tokenPass_r,
  input wire [3:0] timeoutEvt_r,
  input wire [3:0] timeoutSeen_r
);
  // ============================================================
  // request bus and state
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // fresh request: a standing one is not counted twice
  property p_off; netState_r == 2'h0 && $past(netState_r) == 2'h0 |-> !reqValid_r; endproperty
  a_off: assert property (p_off) else $error("request while offline");
  property p_bc;
    reqValid_r && reqKind_r == `FBM_K_BCAST |-> reqAddr_r == `FBM_BCAST_ADDR;
  endproperty
  a_bc: assert property (p_bc) else $error("broadcast address wrong");
  property p_mc;
    reqValid_r && reqKind_r == `FBM_K_MCAST |-> reqAddr_r == `FBM_GROUP_ADDR;
  endproperty
  a_mc: assert property (p_mc) else $error("multicast address wrong");
  property p_stop;
    reqValid_r && !($past(reqValid_r) && !$past(reqReady)) && netState_r == `FBM_ST_STOP
      && $past(netState_r) == `FBM_ST_STOP |-> reqKind_r == `FBM_K_MASTER2;
  endproperty
  a_stop: assert property (p_stop) else $error("slave traffic in stop");
  property p_clr0;
    reqValid_r && !($past(reqValid_r) && !$past(reqReady)) && reqKind_r == `FBM_K_DATA
      && netState_r == `FBM_ST_CLEAR && $past(netState_r) == `FBM_ST_CLEAR |-> reqData_r == 8'h00;
  endproperty
  a_clr0: assert property (p_clr0) else $error("nonzero outputs in clear");
  property p_tok; tokenPass_r |=> !tokenPass_r; endproperty
  a_tok: assert property (p_tok) else $error("token pass not one pulse");
  property p_seen;
    (timeoutSeen_r & $past(timeoutSeen_r | timeoutEvt_r)) == $past(timeoutSeen_r | timeoutEvt_r);
  endproperty
  a_seen: assert property (p_seen) else $error("timeout not kept");
  property p_toff; !netState_r[1] && !$past(netState_r[1]) |-> timeoutEvt_r == 4'h0; endproperty
  a_toff: assert property (p_toff) else $error("timeout outside clear or operate");
  property p_auto;
    xferErr && autoClear && netState_r == `FBM_ST_OPERATE |-> ##[1:4] netState_r == `FBM_ST_CLEAR;
  endproperty
  a_auto: assert property (p_auto) else $error("no auto clear");
  property p_stay;
    xferErr && !autoClear && !cmdValid && netState_r == `FBM_ST_OPERATE |=> netState_r == `FBM_ST_OPERATE;
  endproperty
  a_stay: assert property (p_stay) else $error("left operate");
endmodule
bind fbm_master fbm_master_sva u_sva (.clk, .nrst, .cmdValid, .autoClear, .xferErr, .reqReady,
  .reqValid_r, .reqKind_r, .reqAddr_r, .reqData_r, .netState_r, .tokenPass_r, .timeoutEvt_r,
  .timeoutSeen_r);
`default_nettype wire

// [tb/fbm_slave_model.sv]
`timescale 1ns/100ps
`default_nettype none
`include "fbm_defines.vh"
module fbm_slave_model (
  input  wire            clk,
  input  wire            slow,
  input  wire [3:0]      mute,
  input  wire            reqValid,
  input  wire [2:0]      reqKind,
  input  wire [3:0]      reqAddr,
  output var logic       reqReady,
  output var logic       exchDone,
  output var logic [1:0] exchSlave,
  output var logic       exchOk,
  output var logic [7:0] exchIn
);
  // ============================================================
  // frame engine with slaves behind it
  localparam int WdLimit = 1500;
  int         wd [0:3] = '{default: 0};
  logic [3:0] safe = 4'h0;
  initial {reqReady, exchDone, exchSlave, exchOk, exchIn} = 0;
  always @(posedge clk) begin
    exchDone <= 1'b0;
    exchIn <= ~exchIn; // no stale input value between answers
    reqReady <= slow ? ($urandom % 2 == 0) : 1'b1;
    // a slave that hears nothing from its master goes fail-safe by itself
    for (int s = 0; s < 4; s++) begin
      if (wd[s] < WdLimit) begin
        wd[s] <= wd[s] + 1;
      end else begin
        safe[s] <= 1'b1;
      end
    end
    // broadcast, multicast and fail-safe get no answer; only the polling
    // master is the authorised writer, class 2 traffic never writes
    if (reqValid && reqReady && reqKind <= `FBM_K_DATA && !mute[reqAddr[1:0]]) begin
      exchDone <= 1'b1;
      exchSlave <= reqAddr[1:0];
      exchOk <= 1'b1;
      wd[reqAddr[1:0]] <= 0;
      safe[reqAddr[1:0]] <= 1'b0;
      // readable image of the inputs, top bit shows the fail-safe flag
      exchIn <= 8'h40 + reqAddr + ($urandom & 8'h30) + (safe[reqAddr[1:0]] ? 8'h80 : 8'h00);
    end
  end
endmodule
`default_nettype wire

// [tb/test_fieldbus_master_state_control.sv]
`timescale 1ns/100ps
`default_nettype none
`include "fbm_defines.vh"
module test_fieldbus_master_state_control;
  reg         clk, nrst, cmdValid, autoClear, tokenIn, bcastReq, master2Req, xferErr, slow;
  reg         diagValid, diagReady, acc;
  reg  [1:0]  cmdState;
  reg  [15:0] monInterval, statusInterval, tokenHoldTime;
  reg  [3:0]  baudSel, mute, evt;
  reg  [31:0] appOut;
  reg  [11:0] diagIn;
  reg  [7:0]  img [0:3];
  reg  [11:0] dq [$];
  wire        reqReady, exchDone, exchOk, tokenPass_r, reqValid_r, diagInReady, diagOutValid;
  wire [1:0]  exchSlave, netState_r;
  wire [7:0]  exchIn, reqData_r;
  wire [2:0]  reqKind_r;
  wire [3:0]  reqAddr_r, baudSel_r, timeoutEvt_r, timeoutSeen_r;
  wire [31:0] slvInImg_r;
  wire [11:0] diagOut;
  integer     err_total = 0, n_compared = 0, cyc = 0, nReq = 0, expState = 0, i, k, nPoll = 0;
  integer     kinds [0:7];
  fbm_master u_dut (.clk, .nrst, .cmdValid, .cmdState, .autoClear, .monInterval, .statusInterval,
    .tokenHoldTime, .baudSel, .tokenIn, .bcastReq, .master2Req, .reqReady, .exchDone, .exchSlave,
    .exchOk, .exchIn, .xferErr, .appOut, .diagValid, .diagIn, .diagReady, .tokenPass_r,
    .reqValid_r, .reqKind_r, .reqAddr_r, .reqData_r, .netState_r, .baudSel_r, .timeoutEvt_r,
    .timeoutSeen_r, .slvInImg_r, .diagInReady, .diagOutValid, .diagOut);
  fbm_slave_model u_slv (.clk, .slow, .mute, .reqValid(reqValid_r), .reqKind(reqKind_r),
    .reqAddr(reqAddr_r), .reqReady, .exchDone, .exchSlave, .exchOk, .exchIn);
  // ============================================================
  // helpers
  always #4 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task cmd(input [1:0] s);
    @(negedge clk) cmdValid = 1;
    cmdState = s;
    @(negedge clk) cmdValid = 0;
    expState = s;
    repeat (3) @(negedge clk);
  endtask
  // one token visit; a lost token is cut off after 400 cycles
  task visit;
    for (k = 0; k < 8; k = k + 1) kinds[k] = 0;
    nPoll = 0;
    @(negedge clk) tokenIn = 1;
    k = 0;
    while (tokenPass_r !== 1'b1 && k < 400) begin
      @(negedge clk);
      k = k + 1;
    end
    check(k < 400, 1);
    tokenIn = 0;
    repeat (6) @(negedge clk);
  endtask
  // reference model of the request stream
  always @(negedge clk) begin
    if (reqValid_r === 1'b1 && reqReady) begin
      nReq = nReq + 1;
      kinds[reqKind_r] = kinds[reqKind_r] + 1;
      if (reqKind_r == `FBM_K_DATA)
        check(reqData_r, expState == `FBM_ST_CLEAR ? 8'h00 : appOut[8*reqAddr_r +: 8]);
      if (reqKind_r == `FBM_K_MCAST)
        check(reqData_r, expState);
      // polls go to slaves 0 to 3 in turn within one token visit
      if (reqKind_r <= `FBM_K_DATA) begin
        check(reqAddr_r, nPoll);
        nPoll = nPoll + 1;
      end
    end
    if (exchDone && exchOk)
      img[exchSlave] = exchIn;
    evt = evt | timeoutEvt_r;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      err_total = err_total + 1;
      conclude;
    end
  end
  // ============================================================
  // tests
  initial begin
    k = $urandom(32'h708c);
    {clk, nrst, cmdValid, autoClear, tokenIn, bcastReq, master2Req, xferErr, slow} = 0;
    {diagValid, diagReady, cmdState, baudSel, mute, evt, appOut, diagIn} = 0;
    monInterval = 16'h0300;
    statusInterval = 16'h0040;
    tokenHoldTime = 16'h00c8;
    repeat (3) @(negedge clk);
    nrst = 1;
    repeat (3) @(negedge clk);
    check(netState_r, `FBM_ST_OFFLINE);
    baudSel = $urandom;
    @(negedge clk) tokenIn = 1;
    repeat (20) @(negedge clk);
    tokenIn = 0;
    check(nReq, 0);
    check(baudSel_r, baudSel);
    $display("test offline done");
    cmd(`FBM_ST_STOP);
    @(negedge clk) master2Req = 1;
    @(negedge clk) master2Req = 0;
    visit;
    check(kinds[`FBM_K_MASTER2], 1);
    check(nReq, 1);
    $display("test stop done");
    slow = 1;
    cmd(`FBM_ST_CLEAR);
    for (i = 0; i < 3; i = i + 1) begin
      visit;
      check(kinds[i], 4);
    end
    $display("test clear done");
    appOut = $urandom;
    cmd(`FBM_ST_OPERATE);
    repeat (80) @(negedge clk);
    @(negedge clk) bcastReq = 1;
    @(negedge clk) bcastReq = 0;
    visit;
    check(kinds[`FBM_K_BCAST], 1);
    check(kinds[`FBM_K_MCAST] != 0, 1);
    check(kinds[`FBM_K_DATA], 4);
    check(slvInImg_r, {img[3], img[2], img[1], img[0]});
    $display("test operate done");
    mute = 4'h4;
    for (i = 0; i < 14; i = i + 1) begin
      visit;
      repeat (60) @(negedge clk);
    end
    check(evt, 4'h4);
    check(timeoutSeen_r, 4'h4);
    @(negedge clk) xferErr = 1;
    @(negedge clk) xferErr = 0;
    repeat (4) @(negedge clk);
    check(netState_r, expState);
    $display("test timeout done");
    mute = 0;
    for (i = 0; i < 3; i = i + 1) visit;
    autoClear = 1;
    @(negedge clk) xferErr = 1;
    @(negedge clk) xferErr = 0;
    expState = `FBM_ST_CLEAR;
    repeat (4) @(negedge clk);
    check(netState_r, expState);
    visit;
    check(kinds[`FBM_K_FAILSAFE], 1);
    $display("test autoclear done");
    // far side stalls while the queue fills
    for (i = 0; i < 10; i = i + 1) begin
      @(negedge clk) diagValid = 1;
      diagIn = ($urandom & 12'h3ff) | ((i % 3 + 1) << 10);
      acc = diagInReady;
      @(posedge clk);
      if (acc)
        dq.push_back(diagIn);
    end
    @(negedge clk) diagValid = 0;
    check(dq.size(), `FBM_FIFO_DEPTH);
    check(diagInReady, 0);
    diagReady = 1;
    for (i = 0; i < `FBM_FIFO_DEPTH; i = i + 1) begin
      check(diagOutValid, 1);
      check(diagOut, dq.pop_front());
      @(negedge clk);
    end
    check(diagOutValid, 0);
    $display("test diag done");
    // off-line in mid run: a token must not start any traffic
    cmd(`FBM_ST_OFFLINE);
    i = nReq;
    @(negedge clk) tokenIn = 1;
    repeat (20) @(negedge clk);
    tokenIn = 0;
    check(nReq, i);
    check(netState_r, `FBM_ST_OFFLINE);
    $display("test offline again done");
    conclude;
  end
endmodule
`default_nettype wire
